// *** core/sync_ack_regs.vh ***
`ifndef SYNC_ACK_REGS_VH
`define SYNC_ACK_REGS_VH
// ****************************************************************
// Error output levels (two-bit code on err_level_out)
// ****************************************************************
`define ERR_LVL_PLUS1 2'h1
`define ERR_LVL_ZERO 2'h0
`define ERR_LVL_MINUS1 2'h3
// ****************************************************************
// Timing counts in quarter-rate (CK4) cycles, WCK_PER_CK4 write-clock beats each
// ****************************************************************
`define WCK_PER_CK4 4
`define ACK_PRE_DELAY_CK4 8'h04
`define ACK_POST_DELAY_CK4 8'h08
`define PARITY_UNLOCK_DELAY_CK4 8'h10
`define PARITY_TO_SYNC_BLIND_CK4 8'h06
`define PRE_CSP_WINDOW_CK4 8'h01
// ****************************************************************
// Info read register three
// ****************************************************************
`define INFO3_FEEDBACK_BIT 1
`define INFO3_RESET 8'h02
// ****************************************************************
// Command line pattern of the sync command (lines 1 and 3, 4 beats)
// ****************************************************************
`define SYNC_PAT_LINE1 4'hE
`define SYNC_PAT_LINE3 4'hE
`define SYNC_PAT_OTHER 4'hF
`endif

// *** core/ca_frame_sampler.v ***
`timescale 1ns/1ps
`include "sync_ack_regs.vh"
// ****************************************************************
// Command-address sampler on write data clock edges
// ****************************************************************
module ca_frame_sampler (
  input wire clk_in,
  input wire rst_n_in,
  input wire wck_edge_in,
  input wire [4:0] ca_in,
  input wire parity_in,
  output reg sync_seen_out,
  output reg parity_err_out,
  output reg forced_err_out
);
  reg [3:0] line_ff [0:4];
  reg [3:0] par_hist_ff;
  reg [1:0] low_run_ff [0:4];
  reg [2:0] fill_ff;
  integer i;

  function odd_parity;
    input [4:0] ca;
    input par;
    begin
      odd_parity = ^{ca, par};
    end
  endfunction

  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (i = 0; i < 5; i = i + 1) begin
        line_ff[i] <= 4'h0;
        low_run_ff[i] <= 2'h0;
      end
      par_hist_ff <= 4'h0;
      fill_ff <= 3'h0;
      sync_seen_out <= 1'b0;
      parity_err_out <= 1'b0;
      forced_err_out <= 1'b0;
    end else begin
      sync_seen_out <= 1'b0;
      parity_err_out <= 1'b0;
      forced_err_out <= 1'b0;
      if (wck_edge_in) begin
        for (i = 0; i < 5; i = i + 1) begin
          line_ff[i] <= {line_ff[i][2:0], ca_in[i]};
          if (ca_in[i])
            low_run_ff[i] <= 2'h0;
          else if (low_run_ff[i] != 2'h3)
            low_run_ff[i] <= low_run_ff[i] + 2'h1;
        end
        par_hist_ff <= {par_hist_ff[2:0], odd_parity(ca_in, parity_in)};
        if (fill_ff != 3'h4)
          fill_ff <= fill_ff + 3'h1;
        // Rolling window: every 4-beat group from any phase checked
        if (fill_ff >= 3'h3 && (^{par_hist_ff[2:0], odd_parity(ca_in, parity_in)}))
          parity_err_out <= 1'b1;
        // Three lows on any line force a parity error at any alignment
        for (i = 0; i < 5; i = i + 1)
          if (!ca_in[i] && low_run_ff[i] == 2'h2)
            forced_err_out <= 1'b1;
        if ({line_ff[1][2:0], ca_in[1]} == `SYNC_PAT_LINE1 &&
            {line_ff[3][2:0], ca_in[3]} == `SYNC_PAT_LINE3 &&
            {line_ff[0][2:0], ca_in[0]} == `SYNC_PAT_OTHER &&
            {line_ff[2][2:0], ca_in[2]} == `SYNC_PAT_OTHER &&
            {line_ff[4][2:0], ca_in[4]} == `SYNC_PAT_OTHER)
          sync_seen_out <= 1'b1;
      end
    end
  end
endmodule // ca_frame_sampler

// *** core/sync_command_ack_feedback.v ***
// What this block does
// - Acknowledge sync command after sleep or training exit
// - Feedback on: 0 after pre-delay, +1 after post
// - Feedback off: error output stays at +1 except -1 on a parity error
// - Parity error on sync command reports -1
// - Parity-errored sync is unacknowledged; blocking enters training
// - Parity error just before sync: 0 after -1
// - Missed sync holds 0 until later sync captured
// - Feedback plus blocking: training after unlock, +1
// - Feedback support shown in info register three bit 1
// - Output mapping after sync; parity error wins
// - Parity checked in rolling four-beat window
// - Stress parity error gives -1, blocking trains
// - Sync ignored during blind window after parity error
// - Forced error pattern counts as parity error on a feedback-capable device out of idle
// - After blocked parity error with feedback on refuse commands until training
`timescale 1ns/1ps
`include "sync_ack_regs.vh"
module sync_command_ack_feedback (
  // Clock and reset
  input wire clk_in,
  input wire rst_n_in,
  // Link
  input wire wck_in,
  input wire [4:0] ca_in,
  input wire ca_parity_in,
  // Configuration
  input wire parity_enable_field_in,
  input wire blocking_enable_field_in,
  input wire feedback_enable_field_in,
  input wire feedback_supported_in,
  input wire [3:0] parity_to_flag_latency_in,
  // Events from the rest of the device
  input wire awaiting_sync_in,
  // Status
  output reg [1:0] err_level_out,
  output reg sync_acked_out,
  output reg training_entry_out,
  output reg cmd_block_out,
  output reg [7:0] info_read_register_three_out
);
  // ****************************************************************
  // States
  // ****************************************************************
  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_PRE = 5'h02;
  localparam [4:0] ST_WAIT = 5'h04;
  localparam [4:0] ST_POST = 5'h08;
  localparam [4:0] ST_BLOCK = 5'h10;
  // Blind window in write-clock beats, cut to the counter width on purpose
  localparam [31:0] BLIND_BEATS = `PARITY_TO_SYNC_BLIND_CK4 * `WCK_PER_CK4;

  reg rst_s1_ff, rst_s2_ff;
  wire rst_n;
  reg [2:0] wck_sync_ff;
  reg [4:0] ca_s1_ff, ca_s2_ff;
  reg par_s1_ff, par_s2_ff;
  reg [4:0] lvl_s1_ff, lvl_s2_ff;
  reg await_prev_ff;
  reg [4:0] state_ff, nxt_state;
  reg [7:0] cnt_ff, nxt_cnt;
  reg [1:0] ph_ff;
  reg [7:0] flag_cnt_ff, blind_cnt_ff;
  reg flag_pend_ff, zero_after_ff;
  reg [1:0] base_lvl_ff, nxt_base_lvl;
  reg train_ff, nxt_train;
  wire wck_edge, ck4_tick, sync_seen, par_err, forced_err, any_err, blind;
  wire fb_on, await_rise;

  // ****************************************************************
  // Reset release and input synchronisers
  // ****************************************************************
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_s1_ff <= 1'b0;
      rst_s2_ff <= 1'b0;
    end else begin
      rst_s1_ff <= 1'b1;
      rst_s2_ff <= rst_s1_ff;
    end
  end
  assign rst_n = rst_s2_ff;

  always @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      wck_sync_ff <= 3'h0;
      ca_s1_ff <= 5'h1F;
      ca_s2_ff <= 5'h1F;
      par_s1_ff <= 1'b0;
      par_s2_ff <= 1'b0;
      lvl_s1_ff <= 5'h0;
      lvl_s2_ff <= 5'h0;
    end else begin
      wck_sync_ff <= {wck_sync_ff[1:0], wck_in};
      ca_s1_ff <= ca_in;
      ca_s2_ff <= ca_s1_ff;
      par_s1_ff <= ca_parity_in;
      par_s2_ff <= par_s1_ff;
      lvl_s1_ff <= {awaiting_sync_in, feedback_enable_field_in, blocking_enable_field_in,
                    parity_enable_field_in, feedback_supported_in};
      lvl_s2_ff <= lvl_s1_ff;
    end
  end
  assign wck_edge = wck_sync_ff[1] & ~wck_sync_ff[2];

  ca_frame_sampler u_sampler (
    .clk_in(clk_in),
    .rst_n_in(rst_n),
    .wck_edge_in(wck_edge),
    .ca_in(ca_s2_ff),
    .parity_in(par_s2_ff),
    .sync_seen_out(sync_seen),
    .parity_err_out(par_err),
    .forced_err_out(forced_err)
  );

  // Forced pattern only counts while a feedback-capable device is out of ST_IDLE
  assign any_err = lvl_s2_ff[1] & (par_err |
                   (forced_err & lvl_s2_ff[0] & state_ff != ST_IDLE));
  assign blind = blind_cnt_ff != 8'h00;
  assign fb_on = lvl_s2_ff[0] & lvl_s2_ff[3];
  assign await_rise = lvl_s2_ff[4] & ~await_prev_ff;

  // ****************************************************************
  // Quarter-rate tick and parity flag latency
  // ****************************************************************
  always @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      ph_ff <= 2'h0;
      await_prev_ff <= 1'b0;
      flag_cnt_ff <= 8'h00;
      flag_pend_ff <= 1'b0;
      blind_cnt_ff <= 8'h00;
      zero_after_ff <= 1'b0;
    end else begin
      await_prev_ff <= lvl_s2_ff[4];
      if (wck_edge)
        ph_ff <= ph_ff + 2'h1;
      if (any_err && !flag_pend_ff) begin
        flag_pend_ff <= 1'b1;
        flag_cnt_ff <= {2'h0, parity_to_flag_latency_in, 2'h0};
        blind_cnt_ff <= BLIND_BEATS[7:0];
        zero_after_ff <= fb_on & (state_ff == ST_PRE || state_ff == ST_WAIT);
      end else begin
        if (wck_edge && blind)
          blind_cnt_ff <= blind_cnt_ff - 8'h01;
        if (wck_edge && flag_pend_ff) begin
          if (flag_cnt_ff == 8'h00)
            flag_pend_ff <= 1'b0;
          else
            flag_cnt_ff <= flag_cnt_ff - 8'h01;
        end
      end
    end
  end
  assign ck4_tick = wck_edge & (ph_ff == 2'h3);

  // ****************************************************************
  // Acknowledge sequencer
  // ****************************************************************
  always @* begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_base_lvl = base_lvl_ff;
    nxt_train = 1'b0;
    if (ck4_tick && cnt_ff != 8'h00)
      nxt_cnt = cnt_ff - 8'h01;
    case (state_ff)
      ST_IDLE: begin
        nxt_base_lvl = `ERR_LVL_PLUS1;
        if (await_rise && fb_on) begin
          nxt_state = ST_PRE;
          nxt_cnt = `ACK_PRE_DELAY_CK4;
        end
      end
      ST_PRE: begin
        if (cnt_ff == 8'h00) begin
          nxt_state = ST_WAIT;
          nxt_base_lvl = `ERR_LVL_ZERO;
        end
      end
      ST_WAIT: begin
        nxt_base_lvl = `ERR_LVL_ZERO;
        if (sync_seen && !blind && !any_err && !flag_pend_ff) begin
          nxt_state = ST_POST;
          nxt_cnt = `ACK_POST_DELAY_CK4;
        end
      end
      ST_POST: begin
        if (cnt_ff == 8'h00) begin
          nxt_state = ST_IDLE;
          nxt_base_lvl = `ERR_LVL_PLUS1;
        end
      end
      ST_BLOCK: begin
        if (cnt_ff == 8'h00) begin
          nxt_state = ST_IDLE;
          nxt_train = 1'b1;
          nxt_base_lvl = `ERR_LVL_PLUS1;
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
    // Parity error with blocking overrides all but feedback off: lock and train
    if (any_err && lvl_s2_ff[2] && state_ff != ST_BLOCK) begin
      nxt_state = ST_BLOCK;
      nxt_cnt = `PARITY_UNLOCK_DELAY_CK4;
    end else if (any_err && (state_ff == ST_POST)) begin
      nxt_state = ST_WAIT;
      nxt_base_lvl = `ERR_LVL_ZERO;
    end
    if (!fb_on && state_ff != ST_BLOCK) begin
      nxt_state = ST_IDLE;
      nxt_base_lvl = `ERR_LVL_PLUS1;
    end
  end

  always @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= ST_IDLE;
      cnt_ff <= 8'h00;
      base_lvl_ff <= `ERR_LVL_PLUS1;
      train_ff <= 1'b0;
      err_level_out <= `ERR_LVL_PLUS1;
      sync_acked_out <= 1'b0;
      training_entry_out <= 1'b0;
      cmd_block_out <= 1'b0;
      info_read_register_three_out <= 8'h00;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      base_lvl_ff <= nxt_base_lvl;
      train_ff <= nxt_train;
      training_entry_out <= train_ff;
      sync_acked_out <= (state_ff == ST_POST) && (nxt_state == ST_IDLE);
      cmd_block_out <= (state_ff == ST_BLOCK);
      info_read_register_three_out <= {6'h00, lvl_s2_ff[0], 1'b0};
      // Parity report wins over acknowledge state
      if (flag_pend_ff && flag_cnt_ff == 8'h00)
        err_level_out <= `ERR_LVL_MINUS1;
      else if (zero_after_ff && state_ff == ST_WAIT)
        err_level_out <= `ERR_LVL_ZERO;
      else
        err_level_out <= base_lvl_ff;
    end
  end
endmodule // sync_command_ack_feedback

// *** test/host_link_model.sv ***
`timescale 1ns/1ps
module host_link_model (
  // Run control
  input wire clk_in,
  input wire run_in,
  // Link pins
  output logic wck_out,
  output logic [4:0] ca_out,
  output logic parity_out
);
  logic [5:0] beat_q[$];
  logic [4:0] ph;
  initial begin
    wck_out = 1'b0;
    {ca_out, parity_out} = 6'h3F;
    ph = 5'h00;
  end
  // ****************************************************************
  // Beat engine: one beat per 20 clocks, idle beats all high
  // ****************************************************************
  always @(posedge clk_in) begin
    if (!run_in) begin
      ph <= 5'h00;
      wck_out <= 1'b0;
      ca_out <= ~ca_out;
      parity_out <= ~parity_out;
    end else begin
      ph <= (ph == 5'h13) ? 5'h00 : ph + 5'h01;
      if (ph == 5'h0A) wck_out <= 1'b1;
      if (ph == 5'h00) begin
        wck_out <= 1'b0;
        if (beat_q.size() != 0) {ca_out, parity_out} <= beat_q.pop_front();
        else {ca_out, parity_out} <= 6'h3F;
      end
    end
  end
  // Each beat carries its own parity, inverted when bad is set; a 4-beat window stays clean while it holds an even number of bad beats
  task push(input logic [4:0] ca, input logic bad);
    beat_q.push_back({ca, (^ca) ^ bad});
  endtask
endmodule // host_link_model

// *** test/sync_ack_monitor.sv ***
`timescale 1ns/1ps
`include "sync_ack_regs.vh"
module sync_ack_monitor (
  input wire clk_in,
  input wire rst_n_in,
  input wire parity_enable_field_in,
  input wire feedback_enable_field_in,
  input wire feedback_supported_in,
  input wire [1:0] err_level_out,
  input wire sync_acked_out,
  input wire training_entry_out,
  input wire cmd_block_out,
  input wire [7:0] info_read_register_three_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  logic [3:0] off_ff, poff_ff, sup_cnt_ff;
  logic [7:0] blk_ff;
  logic sup_ff;
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      off_ff <= 4'h0;
      poff_ff <= 4'h0;
      sup_cnt_ff <= 4'h0;
      blk_ff <= 8'h00;
      sup_ff <= 1'b0;
    end else begin
      off_ff <= (parity_enable_field_in | feedback_enable_field_in) ? 4'h0 : off_ff + {3'h0, off_ff != 4'hF};
      poff_ff <= parity_enable_field_in ? 4'h0 : poff_ff + {3'h0, poff_ff != 4'hF};
      sup_ff <= feedback_supported_in;
      sup_cnt_ff <= (sup_ff != feedback_supported_in) ? 4'h0 : sup_cnt_ff + {3'h0, sup_cnt_ff != 4'hF};
      blk_ff <= !cmd_block_out ? 8'h00 : blk_ff + {7'h00, blk_ff != 8'hFF};
    end
  end
  sequence to_plus_s;
    ##[0:2] (err_level_out == `ERR_LVL_PLUS1);
  endsequence
  level_legal_a: assert property (err_level_out != 2'h2)
    else $error("err level code 2 seen");
  fb_off_plus_a: assert property (off_ff >= 4'h8 |-> err_level_out == `ERR_LVL_PLUS1)
    else $error("err left +1 with feedback and parity off");
  par_off_a: assert property (poff_ff >= 4'h8 |-> err_level_out != `ERR_LVL_MINUS1)
    else $error("-1 reported with parity off");
  ack_plus_a: assert property (sync_acked_out |-> to_plus_s)
    else $error("ack without +1");
  train_plus_a: assert property (training_entry_out |-> to_plus_s)
    else $error("training without +1");
  block_hold_a: assert property (cmd_block_out |=> cmd_block_out || training_entry_out)
    else $error("block dropped before training");
  unlock_wait_a: assert property (training_entry_out |-> blk_ff >= 8'h40)
    else $error("training before unlock delay");
  ack_unblocked_a: assert property (sync_acked_out |-> !cmd_block_out)
    else $error("ack while blocked");
  info_bit_a: assert property (sup_cnt_ff >= 4'h6 |-> info_read_register_three_out[1] == sup_ff)
    else $error("info bit 1 wrong");
endmodule // sync_ack_monitor
bind sync_command_ack_feedback sync_ack_monitor mon (.clk_in(clk_in), .rst_n_in(rst_n_in),
  .parity_enable_field_in(parity_enable_field_in),
  .feedback_enable_field_in(feedback_enable_field_in),
  .feedback_supported_in(feedback_supported_in), .err_level_out(err_level_out),
  .sync_acked_out(sync_acked_out), .training_entry_out(training_entry_out),
  .cmd_block_out(cmd_block_out), .info_read_register_three_out(info_read_register_three_out));

// *** test/tb_sync_command_ack_feedback.sv ***
`timescale 1ns/1ps
`include "sync_ack_regs.vh"
module tb_sync_command_ack_feedback;
  logic clk_in, rst_n_in, run, par_en, blk_en, fb_en, fb_sup, awaiting;
  wire write_data_clock, par, acked, train, blk;
  wire [4:0] ca;
  wire [1:0] err;
  wire [7:0] info;
  int miscompares = 0, n_checks = 0, acks = 0, trains = 0, a0, t0;
  host_link_model host (.clk_in(clk_in), .run_in(run), .wck_out(write_data_clock), .ca_out(ca),
    .parity_out(par));
  sync_command_ack_feedback DUT (.clk_in(clk_in), .rst_n_in(rst_n_in), .wck_in(write_data_clock),
    .ca_in(ca), .ca_parity_in(par), .parity_enable_field_in(par_en),
    .blocking_enable_field_in(blk_en), .feedback_enable_field_in(fb_en),
    .feedback_supported_in(fb_sup), .parity_to_flag_latency_in(4'h2),
    .awaiting_sync_in(awaiting), .err_level_out(err), .sync_acked_out(acked),
    .training_entry_out(train), .cmd_block_out(blk), .info_read_register_three_out(info));
  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    acks <= acks + (acked === 1'b1);
    trains <= trains + (train === 1'b1);
  end
  // ****************************************************************
  // Access tasks
  // ****************************************************************
  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task conclude;
    $display("checks=%0d miscompares=%0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task beats(input int n);
    repeat (n * 20) @(posedge clk_in);
  endtask
  task wait_err(input logic [1:0] e, input int n);
    for (int i = 0; i < n * 20 && err !== e; i++) @(posedge clk_in);
    chk({6'h00, err}, {6'h00, e});
    if (err !== e) conclude();
  endtask
  task sync(input logic bad);
    repeat (3) host.push(5'h1F, 1'b0);
    host.push(5'h15, bad);
  endtask
  task arm(input logic f, input logic p, input logic b);
    awaiting <= 1'b0;
    fb_en <= f;
    par_en <= p;
    blk_en <= b;
    beats(2);
    awaiting <= 1'b1;
  endtask
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    {rst_n_in, run, par_en, blk_en, fb_en, awaiting} = 6'h00;
    fb_sup = 1'b1;
    repeat (12) @(posedge clk_in);
    rst_n_in <= 1'b1;
    repeat (8) @(posedge clk_in);
    run <= 1'b1;
    chk({6'h00, err}, 8'h01);
    chk(info, 8'h02);
    arm(1'b0, 1'b1, 1'b0);
    beats(24);
    chk({6'h00, err}, 8'h01);
    repeat (2) begin
      host.push(5'h0A, 1'b0);
      host.push(5'h1F, 1'b0);
    end
    beats(8);
    chk({6'h00, err}, 8'h01);
    sync(1'b0);
    beats(40);
    chk({6'h00, err}, 8'h01);
    a0 = acks;
    arm(1'b1, 1'b1, 1'b0);
    wait_err(`ERR_LVL_ZERO, 20);
    beats(40);
    chk({6'h00, err}, 8'h00);
    sync(1'b0);
    wait_err(`ERR_LVL_PLUS1, 40);
    beats(1);
    chk(8'(acks - a0), 8'h01);
    a0 = acks;
    arm(1'b1, 1'b1, 1'b0);
    wait_err(`ERR_LVL_ZERO, 20);
    sync(1'b1);
    wait_err(`ERR_LVL_MINUS1, 16);
    wait_err(`ERR_LVL_ZERO, 4);
    beats(34);
    sync(1'b0);
    wait_err(`ERR_LVL_PLUS1, 40);
    beats(1);
    chk(8'(acks - a0), 8'h01);
    t0 = trains;
    arm(1'b1, 1'b1, 1'b1);
    wait_err(`ERR_LVL_ZERO, 20);
    repeat (3) host.push(5'h17, 1'b0);
    wait_err(`ERR_LVL_MINUS1, 16);
    beats(1);
    chk({7'h00, blk}, 8'h01);
    wait_err(`ERR_LVL_PLUS1, 90);
    beats(1);
    chk(8'(trains - t0), 8'h01);
    chk({7'h00, blk}, 8'h00);
    fb_sup <= 1'b0;
    beats(1);
    chk(info, 8'h00);
    conclude();
  end
endmodule // tb_sync_command_ack_feedback
